/* File: bench/host_ctrl_model.sv */
`timescale 1ns/100ps
module host_ctrl_model
  import slot_policy_pkg::*;
(
  input  wire logic       clk,
  output cfg_req_t        cfg_bus,
  output logic            lock_valid,
  output logic            lock_data_zone,
  output logic            access_valid,
  output access_req_t     access_req,
  input  wire logic       cfg_ack,
  input  wire logic       cfg_error,
  input  wire logic [7:0] cfg_rdata,
  input  wire logic       lock_ack,
  input  wire logic       lock_error
);
  initial
  begin
    cfg_bus = '0;
    lock_valid = 1'b0;
    lock_data_zone = 1'b0;
    access_valid = 1'b0;
    access_req = '0;
  end

  // one config byte; answer is {ack, error, rdata}
  task automatic cfg(input logic w, input logic [6:0] a,
                     input logic [7:0] d, output logic [9:0] ans);
    @(posedge clk);
    cfg_bus <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(posedge clk);
    cfg_bus.valid <= 1'b0;
    @(negedge clk);
    ans = {cfg_ack, cfg_error, cfg_rdata};
  endtask

  task automatic lock(input logic z, output logic [1:0] ans);
    @(posedge clk);
    lock_valid <= 1'b1;
    lock_data_zone <= z;
    @(posedge clk);
    lock_valid <= 1'b0;
    @(negedge clk);
    ans = {lock_ack, lock_error};
  endtask

  // held across calls, so requests go back to back
  task automatic acc(input access_req_t r);
    @(posedge clk);
    access_valid <= 1'b1;
    access_req <= r;
  endtask

  task automatic idle();
    @(posedge clk);
    access_valid <= 1'b0;
    access_req <= ~access_req;
  endtask
endmodule

/* File: bench/slot_access_policy_check_tb_top.sv */
`timescale 1ns/100ps
module slot_access_policy_check_tb_top
  import slot_policy_pkg::*;
;
  logic        clk;
  logic        rst;
  cfg_req_t    cfg_bus;
  logic        lock_valid;
  logic        lock_data_zone;
  logic        access_valid;
  access_req_t access_req;
  logic        cfg_ack;
  logic        cfg_error;
  logic [7:0]  cfg_rdata;
  logic        lock_ack;
  logic        lock_error;
  logic [7:0]  data_zone_lock_byte;
  logic [7:0]  config_lock_byte;
  logic        resp_valid;
  logic        resp_error;
  verdict_t    resp_verdict;
  int          n_fail = 0;
  int          comparisons = 0;
  slot_cfg_t   cfgm [16];
  bit          copen = 1'b1;
  bit          dopen = 1'b1;
  logic        pv = 1'b0;
  access_req_t pr;
  slot_cfg_t   pc;
  logic [9:0]  ans;
  logic [1:0]  la;

  slot_access_policy_check dut (.clk(clk), .rst(rst), .cfg_bus(cfg_bus),
    .lock_valid(lock_valid), .lock_data_zone(lock_data_zone),
    .access_valid(access_valid), .access_req(access_req),
    .cfg_ack(cfg_ack), .cfg_error(cfg_error), .cfg_rdata(cfg_rdata),
    .lock_ack(lock_ack), .lock_error(lock_error),
    .data_zone_lock_byte(data_zone_lock_byte),
    .config_lock_byte(config_lock_byte), .resp_valid(resp_valid),
    .resp_error(resp_error), .resp_verdict(resp_verdict));

  host_ctrl_model host (.clk(clk), .cfg_bus(cfg_bus),
    .lock_valid(lock_valid), .lock_data_zone(lock_data_zone),
    .access_valid(access_valid), .access_req(access_req),
    .cfg_ack(cfg_ack), .cfg_error(cfg_error), .cfg_rdata(cfg_rdata),
    .lock_ack(lock_ack), .lock_error(lock_error));

  task automatic fail(input string msg);
    n_fail++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask

  task automatic chk(input logic [15:0] got, exp, input string msg);
    comparisons++;
    if (got !== exp)
      fail($sformatf("%s got %h exp %h", msg, got, exp));
  endtask

  task automatic chk_v(input verdict_t got, e, m);
    comparisons++;
    if (((got ^ e) & m) !== '0)
      fail($sformatf("verdict %h exp %h op %0d", got, e, pr.op));
  endtask

  // expected verdict e; m marks the fields that are defined
  task automatic expect_v(input slot_cfg_t c, input access_req_t r,
                          output verdict_t e, output verdict_t m);
    logic       sc;
    logic [3:0] wp;
    e = '0;
    m = '0;
    m.grant = 1'b1;
    sc = c.secret_flag & c.read_cipher_enable;
    wp = c.write_policy;
    if (copen)
      return;
    if (dopen)
    begin
      e.grant = r.op != OP_READ;
      return;
    end
    e.limited_use = c.limited_use_flag & !(r.slot inside {[8:14]});
    m = '1;
    m.parent_source = 1'b0;
    case (r.op)
      OP_READ:
      begin
        e.grant = !(c.secret_flag | c.read_cipher_enable);
        if (sc)
          e.grant = r.len32;
        e.cipher_read = sc;
        e.key_id = c.read_cipher_key_id;
        m.key_id = {4{sc}};
      end
      OP_WRITE:
      begin
        e.mac_required = wp[WP_CIPHER_BIT];
        e.key_id = c.write_auth_key_id;
        if (wp[WP_CIPHER_BIT])
          e.grant = r.len32 & r.mac_ok & r.data_enc;
        else if (wp[3:1] == WP_ALWAYS)
          e.grant = r.len32 | !c.secret_flag;
      end
      OP_KEY_USE:
      begin
        e.grant = !(c.verify_only_flag && r.use_cmd == USE_OTHER);
        e.key_id = r.slot;
      end
      OP_COPY_SOURCE:
      begin
        e.grant = c.read_cipher_key_id == COPY_SRC_KEY;
        m.key_id = '0;
      end
      default:
      begin
        e.grant = wp[WP_DERIVE_BIT] & (!wp[WP_DMAC_BIT] | r.mac_ok);
        e.mac_required = wp[WP_DMAC_BIT];
        e.parent_source = wp[WP_PARENT_BIT];
        e.key_id = wp[WP_PARENT_BIT] ? c.write_auth_key_id : r.slot;
        m.parent_source = 1'b1;
      end
    endcase
    if (!e.grant)
      m = {1'b1, 8'h00};
  endtask

  always @(posedge clk)
  begin
    pv <= access_valid;
    pr <= access_req;
    pc <= cfgm[access_req.slot];
  end

  always @(negedge clk)
  begin
    verdict_t e;
    verdict_t m;
    if (!rst)
    begin
      chk(resp_valid, pv, "resp_valid");
      if (pv)
      begin
        expect_v(pc, pr, e, m);
        chk(resp_error, !e.grant, "resp_error");
        chk_v(resp_verdict, e, m);
      end
    end
  end

  function automatic access_req_t mk_req(int o, int s);
    access_req_t r;
    r = 12'($urandom);
    r.op = op_t'(o);
    r.slot = s[3:0];
    r.use_cmd = use_cmd_t'($urandom_range(2));
    return r;
  endfunction

  task automatic rand_acc(input int k);
    repeat (k)
      host.acc(mk_req($urandom_range(4), $urandom_range(15)));
    host.idle();
  endtask

  task automatic put_slot(input int n);
    slot_cfg_t c;
    c = 16'($urandom);
    c.write_policy = n[3:0];
    // bad combinations kept on purpose
    {c.secret_flag, c.read_cipher_enable} = n[1:0] ^ n[3:2];
    if (!n[0])
      c.read_cipher_key_id = '0;
    host.cfg(1'b1, 7'(SLOT_CFG_BASE + 2 * n), c[7:0], ans);
    chk(ans[9:8], 2'b10, "slot write lo");
    host.cfg(1'b1, 7'(SLOT_CFG_BASE + 2 * n + 1), c[15:8], ans);
    chk(ans[9:8], 2'b10, "slot write hi");
    cfgm[n] = c;
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    #100000;
    fail("watchdog");
    conclude();
  end

  initial
  begin
    access_req_t r;
    void'($urandom(32'hc30c3a4b));
    foreach (cfgm[i])
      cfgm[i] = SLOT_CFG_RESET;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk(data_zone_lock_byte, LOCK_OPEN, "data lock reset");
    chk(config_lock_byte, LOCK_OPEN, "cfg lock reset");
    host.cfg(1'b0, SLOT_CFG_BASE + 7'h0a, 8'h00, ans);
    chk(ans, {2'b10, SLOT_CFG_RESET[7:0]}, "slot reset");
    rand_acc(4);
    host.lock(1'b1, la);
    chk(la, 2'b11, "early data lock");
    for (int n = 0; n < NUM_SLOTS; n++)
      put_slot(n);
    host.cfg(1'b0, SLOT_CFG_LAST, 8'h00, ans);
    chk(ans, {2'b10, cfgm[15][15:8]}, "slot readback");
    host.cfg(1'b1, DATA_LOCK_ADDR, 8'h00, ans);
    chk(ans[9:8], 2'b11, "lock byte write");
    host.cfg(1'b0, 7'h7f, 8'h00, ans);
    chk(ans, 10'h200, "unmapped read");
    host.lock(1'b0, la);
    copen = 1'b0;
    chk(la, 2'b10, "cfg lock");
    chk(config_lock_byte, LOCK_SHUT, "cfg lock byte");
    host.cfg(1'b1, SLOT_CFG_BASE, ~cfgm[0][7:0], ans);
    chk(ans[9:8], 2'b11, "locked write");
    host.cfg(1'b0, SLOT_CFG_BASE, 8'h00, ans);
    chk(ans[7:0], cfgm[0][7:0], "locked keep");
    rand_acc(60);
    host.lock(1'b1, la);
    dopen = 1'b0;
    chk(la, 2'b10, "data lock");
    chk(data_zone_lock_byte, LOCK_SHUT, "data lock byte");
    for (int s = 0; s < NUM_SLOTS; s++)
      for (int o = 0; o < 5; o++)
        for (int l = 0; l < 2; l++)
        begin
          r = mk_req(o, s);
          r.len32 = l[0];
          host.acc(r);
        end
    rand_acc(400);
    repeat (2) @(posedge clk);
    conclude();
  end
endmodule

/* File: core/slot_access_policy_check.sv */
// Functional notes
// - one 16-bit access config word per slot, sixteen slots
// - data zone unlocked: writes allowed once the config zone is locked, reads always refused
// - data zone unlocked only while its lock byte equals 0x55
// - bits 3:0 name the key encrypting read data
// - read key zero lets the slot source a digest-compare copy
// - bit 4 limits the key to compare or compare-bound digests
// - bit 5 flags limited use, ignored for slots 8 to 14
// - bit 6 encrypts reads of secret slots with the read key, no input MAC
// - secret slot: no clear reads, no 4-byte reads or writes
// - bits 11:8 name the key that validates written data
// - bits 15:12 are the write policy
// - secret and cipher read clear: clear reads of 4 or 32 bytes
// - secret without cipher read: all reads refused, key use kept
// - secret and cipher read: encrypted reads, 4-byte refused
// - policy 000x: clear writes of 32 bytes accepted, 4 bytes only for non-secret slots
// - policy 001x or 10xx: write command refused once the data zone is locked
// - policy x1xx: write needs MAC and ciphered data, 32 bytes
// - write and derive decode the policy field independently
`timescale 1ns/100ps
module slot_access_policy_check
  import slot_policy_pkg::*;
#(
  parameter logic [15:0] CFG_RESET = SLOT_CFG_RESET
)
(
  input  wire logic   clk,
  input  wire logic   rst,
  input  cfg_req_t    cfg_bus,
  input  wire logic   lock_valid,
  input  wire logic   lock_data_zone,
  input  wire logic   access_valid,
  input  access_req_t access_req,
  output logic        cfg_ack,
  output logic        cfg_error,
  output logic [7:0]  cfg_rdata,
  output logic        lock_ack,
  output logic        lock_error,
  output logic [7:0]  data_zone_lock_byte,
  output logic [7:0]  config_lock_byte,
  output logic        resp_valid,
  output logic        resp_error,
  output verdict_t    resp_verdict
);

  typedef struct packed {
    slot_cfg_t [NUM_SLOTS-1:0] slot_access_config;
    logic [7:0]                data_lock;
    logic [7:0]                config_lock;
    logic                      cfg_ack;
    logic                      cfg_error;
    logic [7:0]                cfg_rdata;
    logic                      lock_ack;
    logic                      lock_error;
    logic                      resp_valid;
    logic                      resp_error;
    verdict_t                  verdict;
  } policy_state_t;

  policy_state_t state_reg;
  policy_state_t state_next;
  slot_cfg_t     sel_cfg;
  verdict_t      decided;
  logic          data_open;
  logic          cfg_open;
  logic [3:0]    sel_rkey;

  function automatic logic in_slot_range(input logic [6:0] addr);
    in_slot_range = (addr >= SLOT_CFG_BASE) && (addr <= SLOT_CFG_LAST);
  endfunction

  function automatic logic [4:0] byte_index(input logic [6:0] addr);
    logic [6:0] off;
    off = addr - SLOT_CFG_BASE;
    byte_index = off[4:0];
  endfunction

  function automatic logic is_open(input logic [7:0] lock_byte);
    is_open = (lock_byte == LOCK_OPEN);
  endfunction

  assign data_open = is_open(state_reg.data_lock);
  assign cfg_open  = is_open(state_reg.config_lock);
  assign sel_cfg   = state_reg.slot_access_config[access_req.slot];
  assign sel_rkey  = sel_cfg.read_cipher_key_id;

  slot_policy_decode u_decode
  (
    .cfg       (sel_cfg),
    .req       (access_req),
    .data_open (data_open),
    .cfg_open  (cfg_open),
    .verdict   (decided)
  );

  always_comb
  begin
    slot_cfg_t  word;
    logic [4:0] bidx;
    word = '0;
    bidx = byte_index(cfg_bus.addr);
    state_next = state_reg;
    state_next.cfg_ack = cfg_bus.valid;
    state_next.cfg_error = 1'b0;
    state_next.cfg_rdata = 8'h00;
    state_next.lock_ack = lock_valid;
    state_next.lock_error = 1'b0;
    // violations only report; slot data is held elsewhere
    state_next.resp_valid = access_valid;
    state_next.resp_error = access_valid && !decided.grant;
    state_next.verdict = access_valid ? decided : '0;
    if (cfg_bus.valid)
    begin
      if (in_slot_range(cfg_bus.addr))
      begin
        word = state_reg.slot_access_config[bidx[4:1]];
        if (!cfg_bus.write)
          state_next.cfg_rdata = bidx[0] ? word[15:8] : word[7:0];
        else if (!cfg_open)
          state_next.cfg_error = 1'b1;
        else
        begin
          // little-endian byte pair per slot word
          if (bidx[0])
            word[15:8] = cfg_bus.wdata;
          else
            word[7:0] = cfg_bus.wdata;
          state_next.slot_access_config[bidx[4:1]] = word;
        end
      end
      else if (cfg_bus.addr == DATA_LOCK_ADDR)
      begin
        state_next.cfg_rdata = state_reg.data_lock;
        state_next.cfg_error = cfg_bus.write;
      end
      else if (cfg_bus.addr == CFG_LOCK_ADDR)
      begin
        state_next.cfg_rdata = state_reg.config_lock;
        state_next.cfg_error = cfg_bus.write;
      end
      else
        state_next.cfg_error = cfg_bus.write;
    end
    if (lock_valid)
    begin
      if (!lock_data_zone)
        state_next.config_lock = LOCK_SHUT;
      else if (cfg_open)
        state_next.lock_error = 1'b1;
      else
        state_next.data_lock = LOCK_SHUT;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '0;
      state_reg.slot_access_config <= {NUM_SLOTS{CFG_RESET}};
      state_reg.data_lock <= LOCK_OPEN;
      state_reg.config_lock <= LOCK_OPEN;
    end
    else
      state_reg <= state_next;
  end

  assign cfg_ack             = state_reg.cfg_ack;
  assign cfg_error           = state_reg.cfg_error;
  assign cfg_rdata           = state_reg.cfg_rdata;
  assign lock_ack            = state_reg.lock_ack;
  assign lock_error          = state_reg.lock_error;
  assign data_zone_lock_byte = state_reg.data_lock;
  assign config_lock_byte    = state_reg.config_lock;
  assign resp_valid          = state_reg.resp_valid;
  assign resp_error          = state_reg.resp_error;
  assign resp_verdict        = state_reg.verdict;

  a_unlocked_read: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && access_req.op == OP_READ && data_open
    |=> resp_valid && resp_error && !resp_verdict.grant)
    else $error("read granted while data zone unlocked");

  a_unlocked_write: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && access_req.op == OP_WRITE && data_open && !cfg_open
    |=> resp_verdict.grant && !resp_error)
    else $error("write refused while data zone unlocked");

  a_lock_sticky: assert property (
    @(posedge clk) disable iff (rst)
    data_zone_lock_byte != LOCK_OPEN |=> $stable(data_zone_lock_byte))
    else $error("data zone lock byte changed after lock");

  a_cipher_read_key: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && access_req.op == OP_READ && !data_open && !cfg_open
    && sel_cfg.secret_flag && sel_cfg.read_cipher_enable
    && access_req.len32
    |=> resp_verdict.grant && resp_verdict.cipher_read
        && !resp_verdict.mac_required
        && resp_verdict.key_id == $past(sel_rkey))
    else $error("encrypted read key or grant wrong");

  a_copy_source: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && access_req.op == OP_COPY_SOURCE
    && !data_open && !cfg_open
    |=> resp_verdict.grant == ($past(sel_rkey) == COPY_SRC_KEY))
    else $error("copy source grant does not follow read key");

  a_verify_only: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && access_req.op == OP_KEY_USE && !data_open
    && !cfg_open && sel_cfg.verify_only_flag
    && access_req.use_cmd == USE_OTHER
    |=> resp_valid && resp_error)
    else $error("verify-only key used by other command");

  a_limited_skip: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && access_req.slot >= LIMITED_SKIP_LO
    && access_req.slot <= LIMITED_SKIP_HI
    |=> !resp_verdict.limited_use)
    else $error("limited use reported for slot 8 to 14");

  a_secret_short: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && !data_open && !access_req.len32
    && (access_req.op == OP_READ || access_req.op == OP_WRITE)
    && sel_cfg.secret_flag
    |=> resp_error)
    else $error("4-byte access to secret slot granted");

  a_clear_read: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && access_req.op == OP_READ && !data_open && !cfg_open
    && !sel_cfg.secret_flag && !sel_cfg.read_cipher_enable
    |=> resp_verdict.grant && !resp_verdict.cipher_read)
    else $error("clear read of public slot refused");

  a_secret_noread: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && access_req.op == OP_READ
    && sel_cfg.secret_flag && !sel_cfg.read_cipher_enable
    |=> resp_error)
    else $error("read of key-only slot granted");

  a_write_never: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && access_req.op == OP_WRITE && !data_open
    && (sel_cfg.write_policy[3:1] == WP_NEVER_A
        || sel_cfg.write_policy[3:2] == WP_NEVER_B)
    |=> resp_error)
    else $error("write granted to never-write slot");

  a_write_cipher: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && access_req.op == OP_WRITE && !data_open
    && sel_cfg.write_policy[WP_CIPHER_BIT]
    && !(access_req.mac_ok && access_req.data_enc && access_req.len32)
    |=> resp_error && resp_verdict.mac_required)
    else $error("encrypted-mode write accepted without MAC");

  a_derive_target: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && access_req.op == OP_DERIVE && !data_open
    && !sel_cfg.write_policy[WP_DERIVE_BIT]
    |=> resp_error)
    else $error("derive granted on non-target slot");

  a_error_pair: assert property (
    @(posedge clk) disable iff (rst)
    resp_valid |-> resp_error == !resp_verdict.grant)
    else $error("error status disagrees with grant");

  a_cfg_locked: assert property (
    @(posedge clk) disable iff (rst)
    !cfg_open && !(lock_valid && !lock_data_zone)
    |=> $stable(state_reg.slot_access_config))
    else $error("slot config changed after config lock");

  a_short_cipher: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && access_req.op == OP_READ && !data_open
    && sel_cfg.secret_flag && sel_cfg.read_cipher_enable
    && !access_req.len32
    |=> resp_error && resp_verdict.cipher_read)
    else $error("4-byte encrypted read granted");

  a_write_key: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && access_req.op == OP_WRITE && !data_open
    |=> resp_verdict.key_id == $past(sel_cfg.write_auth_key_id))
    else $error("write key id does not follow config");

  a_write_always: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && access_req.op == OP_WRITE && !data_open
    && sel_cfg.write_policy[3:1] == WP_ALWAYS
    && (access_req.len32 || !sel_cfg.secret_flag)
    |=> resp_verdict.grant && !resp_error)
    else $error("clear write refused in always mode");

  a_cipher_write_ok: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && access_req.op == OP_WRITE && !data_open
    && sel_cfg.write_policy[WP_CIPHER_BIT] && access_req.len32
    && access_req.mac_ok && access_req.data_enc
    |=> resp_verdict.grant && resp_verdict.mac_required)
    else $error("authorised encrypted write refused");

  a_derive_source: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && access_req.op == OP_DERIVE && !data_open
    |=> resp_verdict.parent_source
        == $past(sel_cfg.write_policy[WP_PARENT_BIT])
        && resp_verdict.mac_required
        == $past(sel_cfg.write_policy[WP_DMAC_BIT]))
    else $error("derive source or MAC flag wrong");

  a_unlocked_use: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && access_req.op != OP_READ && data_open && !cfg_open
    |=> resp_verdict.grant)
    else $error("restriction applied while data zone unlocked");

  a_cfg_open_refuse: assert property (
    @(posedge clk) disable iff (rst)
    access_valid && cfg_open |=> resp_error)
    else $error("data access granted before config lock");

  a_idle_quiet: assert property (
    @(posedge clk) disable iff (rst)
    !resp_valid |-> resp_verdict == '0 && !resp_error)
    else $error("verdict shown without a request");

  a_cfg_write_lock: assert property (
    @(posedge clk) disable iff (rst)
    cfg_bus.valid && cfg_bus.write && !cfg_open
    |=> cfg_ack && cfg_error)
    else $error("config write accepted after config lock");

  a_early_lock: assert property (
    @(posedge clk) disable iff (rst)
    lock_valid && lock_data_zone && cfg_open
    |=> lock_ack && lock_error && data_zone_lock_byte == LOCK_OPEN)
    else $error("data zone locked before config zone");

  a_cfg_sticky: assert property (
    @(posedge clk) disable iff (rst)
    config_lock_byte != LOCK_OPEN |=> $stable(config_lock_byte))
    else $error("config lock byte changed after lock");

endmodule

/* File: core/slot_policy_decode.sv */
`timescale 1ns/100ps
module slot_policy_decode
  import slot_policy_pkg::*;
(
  input  slot_cfg_t   cfg,
  input  access_req_t req,
  input  wire logic   data_open,
  input  wire logic   cfg_open,
  output verdict_t    verdict
);

  logic [3:0] wp;
  logic       skip;

  assign wp = cfg.write_policy;
  assign skip = (req.slot >= LIMITED_SKIP_LO)
             && (req.slot <= LIMITED_SKIP_HI);

  always_comb
  begin
    verdict = '0;
    verdict.limited_use = cfg.limited_use_flag && !skip;
    if (cfg_open)
      verdict.grant = 1'b0;
    else if (data_open)
      verdict.grant = (req.op != OP_READ);
    else
      case (req.op)
        OP_READ:
        begin
          if (cfg.secret_flag && cfg.read_cipher_enable)
          begin
            verdict.grant = req.len32;
            verdict.cipher_read = 1'b1;
            verdict.key_id = cfg.read_cipher_key_id;
          end
          else
            verdict.grant = !cfg.secret_flag && !cfg.read_cipher_enable;
        end
        OP_WRITE:
        begin
          verdict.key_id = cfg.write_auth_key_id;
          if (wp[WP_CIPHER_BIT])
          begin
            verdict.mac_required = 1'b1;
            verdict.grant = req.len32 && req.mac_ok && req.data_enc;
          end
          else if (wp[3:1] == WP_ALWAYS)
            verdict.grant = req.len32 || !cfg.secret_flag;
          else
            verdict.grant = 1'b0;
        end
        OP_KEY_USE:
        begin
          verdict.key_id = req.slot;
          verdict.grant = !cfg.verify_only_flag
                       || (req.use_cmd != USE_OTHER);
        end
        OP_COPY_SOURCE:
          verdict.grant = (cfg.read_cipher_key_id == COPY_SRC_KEY);
        OP_DERIVE:
        begin
          // separate decode of the same field
          verdict.parent_source = wp[WP_PARENT_BIT];
          verdict.mac_required = wp[WP_DMAC_BIT];
          verdict.key_id = wp[WP_PARENT_BIT] ? cfg.write_auth_key_id
                                             : req.slot;
          verdict.grant = wp[WP_DERIVE_BIT]
                       && (!wp[WP_DMAC_BIT] || req.mac_ok);
        end
        default:
          verdict.grant = 1'b0;
      endcase
  end

endmodule

/* File: core/slot_policy_pkg.sv */
package slot_policy_pkg;

  localparam int NUM_SLOTS = 16;

  // configuration zone byte addresses
  localparam logic [6:0] SLOT_CFG_BASE  = 7'h14;
  localparam logic [6:0] SLOT_CFG_LAST  = 7'h33;
  localparam logic [6:0] DATA_LOCK_ADDR = 7'h56;
  localparam logic [6:0] CFG_LOCK_ADDR  = 7'h57;

  localparam logic [7:0] LOCK_OPEN = 8'h55;
  localparam logic [7:0] LOCK_SHUT = 8'h00;
  localparam logic [15:0] SLOT_CFG_RESET = 16'h0000;

  // slots whose limited-use flag is ignored, and the read key that allows copy source
  localparam logic [3:0] LIMITED_SKIP_LO = 4'h8;
  localparam logic [3:0] LIMITED_SKIP_HI = 4'he;
  localparam logic [3:0] COPY_SRC_KEY    = 4'h0;

  // write_policy field bits
  localparam int WP_PARENT_BIT = 0;
  localparam int WP_DERIVE_BIT = 1;
  localparam int WP_CIPHER_BIT = 2;
  localparam int WP_DMAC_BIT   = 3;
  localparam logic [2:0] WP_ALWAYS = 3'h0;
  localparam logic [2:0] WP_NEVER_A = 3'h1;
  localparam logic [1:0] WP_NEVER_B = 2'h2;

  typedef struct packed {
    logic [3:0] write_policy;
    logic [3:0] write_auth_key_id;
    logic       secret_flag;
    logic       read_cipher_enable;
    logic       limited_use_flag;
    logic       verify_only_flag;
    logic [3:0] read_cipher_key_id;
  } slot_cfg_t;

  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_KEY_USE, OP_COPY_SOURCE, OP_DERIVE
  } op_t;

  typedef enum logic [1:0] {
    USE_COMPARE, USE_GEN_FOR_COMPARE, USE_OTHER
  } use_cmd_t;

  typedef struct packed {
    op_t        op;
    logic [3:0] slot;
    logic       len32;
    use_cmd_t   use_cmd;
    logic       mac_ok;
    logic       data_enc;
  } access_req_t;

  typedef struct packed {
    logic       grant;
    logic       cipher_read;
    logic       mac_required;
    logic       limited_use;
    logic       parent_source;
    logic [3:0] key_id;
  } verdict_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cfg_req_t;

endpackage
